/* rtl/dwb_pkg.sv */
package dwb_pkg;

  // Configuration header window registers (byte addresses)
  localparam logic [31:0] ADDR_WIN1_BASE  = 32'h0000_0018;
  localparam logic [31:0] ADDR_WIN2_BASE  = 32'h0000_001C;
  localparam logic [31:0] ADDR_XLAT1      = 32'h0000_00A8;
  localparam logic [31:0] ADDR_SETUP1     = 32'h0000_00AC;

  // Internal register space sits above the header
  localparam logic [31:0] ADDR_CSR_BASE   = 32'h0000_1000;
  localparam logic [31:0] CSR_OFS_XLAT2   = 32'h0000_0008;
  localparam logic [31:0] CSR_OFS_SETUP2  = 32'h0000_000C;
  localparam logic [31:0] ADDR_XLAT2      = ADDR_CSR_BASE + CSR_OFS_XLAT2;
  localparam logic [31:0] ADDR_SETUP2     = ADDR_CSR_BASE + CSR_OFS_SETUP2;

  // Window register field layout
  localparam int unsigned BIT_SPACE       = 0;
  localparam int unsigned TYPE_LSB        = 1;
  localparam int unsigned TYPE_MSB        = 2;
  localparam int unsigned BIT_PREF        = 3;
  localparam int unsigned BASE_LSB        = 12;
  localparam int unsigned BIT_EN          = 31;
  localparam int unsigned BASE_W          = 20;

  // Address type codes
  localparam logic [1:0]  TYPE_DEC32      = 2'h0;
  localparam logic [1:0]  TYPE_DEC64      = 2'h1;
  localparam logic        SPACE_MEM       = 1'h0;

  // Reset values
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;
  localparam logic [19:0] RST_BASE        = 20'h0_0000;
  localparam logic [7:0]  RSVD_ZERO       = 8'h00;

  // Loader targets for the serial memory and management bus paths
  localparam logic [1:0]  LD_SETUP1       = 2'h0;
  localparam logic [1:0]  LD_XLAT1        = 2'h1;
  localparam logic [1:0]  LD_SETUP2       = 2'h2;
  localparam logic [1:0]  LD_XLAT2        = 2'h3;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic        HRESP_OKAY      = 1'h0;

  typedef enum logic {DWB_BUS_IDLE, DWB_BUS_RD_WAIT} dwb_bus_st_t;

endpackage : dwb_pkg

/* rtl/dwb_window.sv */
`timescale 1ns/1ps
module dwb_window #(
  parameter bit MEM_ONLY = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] setup,
  input  wire logic [31:0] xlat_base,
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] dec_addr,
  output logic      [31:0] rd_value,
  output logic             hit,
  output logic      [31:0] xlat_addr
);
  import dwb_pkg::*;

  logic [BASE_W-1:0] mask;
  logic [BASE_W-1:0] base;
  logic [BASE_W-1:0] next_base;
  logic              enabled;
  logic              space;
  logic [1:0]        atype;
  logic              pref;

  // Writable base bits follow the setup word
  assign mask = setup[31:BASE_LSB];
  assign enabled = setup[BIT_EN] & (|mask);
  // bit 31 in mask caps size at 2GB
  // space bit follows setup, memory only on two
  assign space = MEM_ONLY ? SPACE_MEM : setup[BIT_SPACE];
  // only 32 or 64 bit decode reported
  // second window fixed at 32 bit
  always_comb begin
    if (MEM_ONLY) begin
      atype = TYPE_DEC32;
    end else if (setup[TYPE_MSB:TYPE_LSB] == TYPE_DEC64) begin
      atype = TYPE_DEC64;
    end else begin
      atype = TYPE_DEC32; // Reserved codes fall back to 32 bit
    end
  end
  // prefetch bit read only from setup
  assign pref = setup[BIT_PREF];

  always_comb begin
    next_base = base;
    if (wr_en && enabled) begin
      next_base = wdata[31:BASE_LSB] & mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base <= RST_BASE;
    end else begin
      base <= next_base;
    end
  end

  // Disabled window hides itself entirely from enumeration
  // bits 11 to 4 read zero
  always_comb begin
    if (enabled) begin
      rd_value = {base & mask, RSVD_ZERO, pref, atype, space};
    end else begin
      rd_value = RST_WORD;
    end
  end

  // Mask also reapplied on read, setup may shrink after a write
  assign hit = enabled &&
               ((dec_addr[31:BASE_LSB] & mask) == (base & mask));

  assign xlat_addr = {(xlat_base[31:BASE_LSB] & mask) |
                      (dec_addr[31:BASE_LSB] & ~mask),
                      dec_addr[BASE_LSB-1:0]};

endmodule : dwb_window

/* rtl/dwb_bars.sv */
`timescale 1ns/1ps
module dwb_bars (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        eeprom_ld_valid,
  input  wire logic [1:0]  eeprom_ld_sel,
  input  wire logic [31:0] eeprom_ld_data,
  input  wire logic        smbus_ld_valid,
  input  wire logic [1:0]  smbus_ld_sel,
  input  wire logic [31:0] smbus_ld_data,
  input  wire logic        dec_valid,
  input  wire logic [31:0] dec_addr,
  output logic             win1_hit,
  output logic             win2_hit,
  output logic             xlat_valid,
  output logic      [31:0] xlat_addr
);
  import dwb_pkg::*;

  // Bus phase tracking
  dwb_bus_st_t bus_st;
  dwb_bus_st_t next_bus_st;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] rd_addr;
  logic [31:0] next_rd_addr;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic        accept;
  logic        rd_req;
  logic        wr_req;

  // Setup and translated base words
  logic [31:0] setup1;
  logic [31:0] next_setup1;
  logic [31:0] xlat1;
  logic [31:0] next_xlat1;
  logic [31:0] setup2;
  logic [31:0] next_setup2;
  logic [31:0] xlat2;
  logic [31:0] next_xlat2;

  // Window instance wiring
  logic        bar1_wr;
  logic        bar2_wr;
  logic [31:0] bar1_rd;
  logic [31:0] bar2_rd;
  logic        bar1_hit;
  logic        bar2_hit;
  logic [31:0] bar1_xlat;
  logic [31:0] bar2_xlat;
  logic [31:0] rd_mux;

  // Decode result registers
  logic        next_win1_hit;
  logic        next_win2_hit;
  logic        next_xlat_valid;
  logic [31:0] next_xlat_addr;

  // Address phase qualifiers
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_req = accept && !hwrite;
  // Only whole words land; narrower writes are dropped harmlessly
  assign wr_req = accept && hwrite && (hsize == HSIZE_WORD);

  // Bus sequencer: writes are zero wait, reads take one wait state.
  // The wait lets a write in the previous data phase settle first,
  // so read-after-write never returns stale data.
  always_comb begin
    next_bus_st    = bus_st;
    next_wr_pend   = wr_req;
    next_wr_addr   = wr_addr;
    next_rd_addr   = rd_addr;
    next_hreadyout = 1'b1;
    next_hrdata    = hrdata;
    if (wr_req) begin
      next_wr_addr = haddr;
    end
    unique case (bus_st)
      DWB_BUS_IDLE: begin
        if (rd_req) begin
          next_bus_st    = DWB_BUS_RD_WAIT;
          next_rd_addr   = haddr;
          next_hreadyout = 1'b0;
        end
      end
      DWB_BUS_RD_WAIT: begin
        next_bus_st    = DWB_BUS_IDLE;
        next_hrdata    = rd_mux;
        next_hreadyout = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st    <= DWB_BUS_IDLE;
      wr_pend   <= 1'b0;
      wr_addr   <= RST_WORD;
      rd_addr   <= RST_WORD;
      hreadyout <= 1'b1;
      hrdata    <= RST_WORD;
      hresp     <= HRESP_OKAY;
    end else begin
      bus_st    <= next_bus_st;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      rd_addr   <= next_rd_addr;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= HRESP_OKAY; // No error answer exists here
    end
  end

  // Host writes to the two window registers
  assign bar1_wr = wr_pend && (wr_addr == ADDR_WIN1_BASE);
  assign bar2_wr = wr_pend && (wr_addr == ADDR_WIN2_BASE);

  // three load paths into setup and translated base words
  // Host bus write wins, then management bus, then serial memory.
  // Loads are meant to finish before host enumeration starts.
  always_comb begin
    next_setup1 = setup1;
    next_xlat1  = xlat1;
    next_setup2 = setup2;
    next_xlat2  = xlat2;
    if (eeprom_ld_valid) begin
      unique case (eeprom_ld_sel)
        LD_SETUP1: next_setup1 = eeprom_ld_data;
        LD_XLAT1:  next_xlat1  = eeprom_ld_data;
        LD_SETUP2: next_setup2 = eeprom_ld_data;
        LD_XLAT2:  next_xlat2  = eeprom_ld_data;
      endcase
    end
    if (smbus_ld_valid) begin
      unique case (smbus_ld_sel)
        LD_SETUP1: next_setup1 = smbus_ld_data;
        LD_XLAT1:  next_xlat1  = smbus_ld_data;
        LD_SETUP2: next_setup2 = smbus_ld_data;
        LD_XLAT2:  next_xlat2  = smbus_ld_data;
      endcase
    end
    if (wr_pend) begin
      // setup one at header offset ACh
      if (wr_addr == ADDR_SETUP1) begin
        next_setup1 = hwdata;
      end
      if (wr_addr == ADDR_XLAT1) begin
        next_xlat1 = hwdata;
      end
      if (wr_addr == ADDR_SETUP2) begin
        next_setup2 = hwdata;
      end
      if (wr_addr == ADDR_XLAT2) begin
        next_xlat2 = hwdata;
      end
    end
  end

  // Cleared at reset: both windows start disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup1 <= RST_WORD;
      xlat1  <= RST_WORD;
      setup2 <= RST_WORD;
      xlat2  <= RST_WORD;
    end else begin
      setup1 <= next_setup1;
      xlat1  <= next_xlat1;
      setup2 <= next_setup2;
      xlat2  <= next_xlat2;
    end
  end

  // window one shaped by setup one
  dwb_window #(
    .MEM_ONLY (1'b0)
  ) u_win1 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .setup     (setup1),
    .xlat_base (xlat1),
    .wr_en     (bar1_wr),
    .wdata     (hwdata),
    .dec_addr  (dec_addr),
    .rd_value  (bar1_rd),
    .hit       (bar1_hit),
    .xlat_addr (bar1_xlat)
  );

  // window two shaped by setup two
  dwb_window #(
    .MEM_ONLY (1'b1)
  ) u_win2 (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .setup     (setup2),
    .xlat_base (xlat2),
    .wr_en     (bar2_wr),
    .wdata     (hwdata),
    .dec_addr  (dec_addr),
    .rd_value  (bar2_rd),
    .hit       (bar2_hit),
    .xlat_addr (bar2_xlat)
  );

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      ADDR_WIN1_BASE: rd_mux = bar1_rd;
      ADDR_WIN2_BASE: rd_mux = bar2_rd;
      ADDR_SETUP1:    rd_mux = setup1;
      ADDR_XLAT1:     rd_mux = xlat1;
      ADDR_SETUP2:    rd_mux = setup2;
      ADDR_XLAT2:     rd_mux = xlat2;
      default:        rd_mux = RST_WORD;
    endcase
  end

  // Downstream decode and translation, one cycle of latency.
  // Window one takes priority if software lets the two overlap.
  always_comb begin
    next_win1_hit   = 1'b0;
    next_win2_hit   = 1'b0;
    next_xlat_valid = 1'b0;
    next_xlat_addr  = xlat_addr;
    if (dec_valid) begin
      if (bar1_hit) begin
        next_win1_hit   = 1'b1;
        next_xlat_valid = 1'b1;
        next_xlat_addr  = bar1_xlat;
      end else if (bar2_hit) begin
        next_win2_hit   = 1'b1;
        next_xlat_valid = 1'b1;
        next_xlat_addr  = bar2_xlat;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win1_hit   <= 1'b0;
      win2_hit   <= 1'b0;
      xlat_valid <= 1'b0;
      xlat_addr  <= RST_WORD;
    end else begin
      win1_hit   <= next_win1_hit;
      win2_hit   <= next_win2_hit;
      xlat_valid <= next_xlat_valid;
      xlat_addr  <= next_xlat_addr;
    end
  end

endmodule : dwb_bars

/* test/dwb_bars_chk.sv */
`timescale 1ns/1ps
module dwb_bars_chk
  import dwb_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        dec_valid,
  input wire logic [31:0] dec_addr,
  input wire logic        win1_hit,
  input wire logic        win2_hit,
  input wire logic        xlat_valid,
  input wire logic [31:0] xlat_addr
);
  logic [31:0] rd_addr;
  logic [31:0] next_rd_addr;

  // Remember which register the pending read targets
  always_comb begin
    next_rd_addr = rd_addr;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      next_rd_addr = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_addr <= RST_WORD;
    end else begin
      rd_addr <= next_rd_addr;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  a_read_wait: assert property (hsel && hready &&
    htrans == HTRANS_NONSEQ && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_xlat_pair: assert property (
    xlat_valid == (win1_hit || win2_hit))
    else $error("xlat valid not tied to hits");
  a_hit_excl: assert property (!(win1_hit && win2_hit))
    else $error("both windows hit");
  a_hit_cause: assert property ((win1_hit || win2_hit) |->
    $past(dec_valid)) else $error("hit without decode request");
  a_xlat_low: assert property (xlat_valid |->
    (($past(dec_addr) ^ xlat_addr) & 32'h0000_0FFF) == 32'h0)
    else $error("xlat low bits changed");
  a_rsvd_zero: assert property ($rose(hreadyout) &&
    (rd_addr == ADDR_WIN1_BASE || rd_addr == ADDR_WIN2_BASE) |->
    hrdata[11:4] == RSVD_ZERO) else $error("reserved bits not zero");
  a_win1_type: assert property ($rose(hreadyout) &&
    rd_addr == ADDR_WIN1_BASE |-> !hrdata[2])
    else $error("window one reserved type");
  a_win2_low: assert property ($rose(hreadyout) &&
    rd_addr == ADDR_WIN2_BASE |-> hrdata[2:0] == 3'h0)
    else $error("window two type or space wrong");
endmodule : dwb_bars_chk

bind dwb_bars dwb_bars_chk dwb_bars_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .dec_valid(dec_valid),
  .dec_addr(dec_addr), .win1_hit(win1_hit), .win2_hit(win2_hit),
  .xlat_valid(xlat_valid), .xlat_addr(xlat_addr)
);

/* test/dwb_bars_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dwb_bars_bench;
  import dwb_pkg::*;
  logic        hclk            = 1'b0;
  logic        hresetn         = 1'b0;
  logic        hsel            = 1'b0;
  logic [31:0] haddr           = 32'h0;
  logic [1:0]  htrans          = 2'h0;
  logic        hwrite          = 1'b0;
  logic [2:0]  hsize           = HSIZE_WORD;
  logic [31:0] hwdata          = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        eeprom_ld_valid = 1'b0;
  logic [1:0]  eeprom_ld_sel   = 2'h0;
  logic [31:0] eeprom_ld_data  = 32'h0;
  logic        smbus_ld_valid  = 1'b0;
  logic [1:0]  smbus_ld_sel    = 2'h0;
  logic [31:0] smbus_ld_data   = 32'h0;
  logic        dec_valid       = 1'b0;
  logic [31:0] dec_addr        = 32'h0;
  logic        win1_hit;
  logic        win2_hit;
  logic        xlat_valid;
  logic [31:0] xlat_addr;
  logic [31:0] q;
  int          fails           = 0;
  int          check_count     = 0;

  dwb_bars dwb_bars_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .eeprom_ld_valid(eeprom_ld_valid),
    .eeprom_ld_sel(eeprom_ld_sel), .eeprom_ld_data(eeprom_ld_data),
    .smbus_ld_valid(smbus_ld_valid), .smbus_ld_sel(smbus_ld_sel),
    .smbus_ld_data(smbus_ld_data), .dec_valid(dec_valid),
    .dec_addr(dec_addr), .win1_hit(win1_hit), .win2_hit(win2_hit),
    .xlat_valid(xlat_valid), .xlat_addr(xlat_addr)
  );

  // 50 MHz clock
  initial begin
    forever #10 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK($sformatf("rd %h", a), e, q)
  endtask : rd_chk

  // One-cycle load strobe from the serial memory or management bus
  task automatic ld(input logic smb, input logic [1:0] s,
                    input logic [31:0] d);
    @(posedge hclk);
    eeprom_ld_valid <= !smb;
    smbus_ld_valid  <= smb;
    eeprom_ld_sel   <= s;
    smbus_ld_sel    <= s;
    eeprom_ld_data  <= d;
    smbus_ld_data   <= d;
    @(posedge hclk);
    eeprom_ld_valid <= 1'b0;
    smbus_ld_valid  <= 1'b0;
  endtask : ld

  // Answer lands one cycle after the request edge
  task automatic dec(input logic [31:0] a, input logic h1, input logic h2,
                     input logic [31:0] x);
    @(posedge hclk);
    dec_valid <= 1'b1;
    dec_addr  <= a;
    @(posedge hclk);
    dec_valid <= 1'b0;
    @(posedge hclk);
    `CHK("win1_hit", h1, win1_hit)
    `CHK("win2_hit", h2, win2_hit)
    `CHK("xlat_valid", h1 | h2, xlat_valid)
    if (h1 | h2) `CHK("xlat_addr", x, xlat_addr)
  endtask : dec

  // Whole run is about 120 cycles; this leaves wide margin
  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_WIN1_BASE, RST_WORD);
    rd_chk(ADDR_WIN2_BASE, RST_WORD);
    ahb(1'b1, ADDR_WIN1_BASE, 32'hFFFF_FFFF);
    rd_chk(ADDR_WIN1_BASE, RST_WORD);
    dec(32'h0000_0000, 1'b0, 1'b0, 32'h0);
    $display("test reset done");
    ahb(1'b1, ADDR_SETUP1, 32'hFFF0_000A);
    rd_chk(ADDR_WIN1_BASE, 32'h0000_000A);
    ahb(1'b1, ADDR_WIN1_BASE, 32'hFFFF_FFFF);
    rd_chk(ADDR_WIN1_BASE, 32'hFFF0_000A);
    ahb(1'b1, ADDR_WIN1_BASE, 32'h1234_5678);
    rd_chk(ADDR_WIN1_BASE, 32'h1230_000A);
    ahb(1'b1, ADDR_XLAT1, 32'hABCD_E000);
    dec(32'h1234_56F0, 1'b1, 1'b0, 32'hABC4_56F0);
    dec(32'h1240_00F0, 1'b0, 1'b0, 32'h0);
    for (int c = 0; c < 4; c++) begin
      ld(1'b0, LD_SETUP1, 32'hFFF0_0000 | (32'(c) << 1));
      rd_chk(ADDR_WIN1_BASE, 32'h1230_0000 | (c == 1 ? 32'h2 : 32'h0));
    end
    ld(1'b0, LD_SETUP1, 32'hFFFF_F001);
    rd_chk(ADDR_WIN1_BASE, 32'h1230_0001);
    ld(1'b0, LD_SETUP1, 32'h0000_0000);
    rd_chk(ADDR_WIN1_BASE, RST_WORD);
    $display("test window one done");
    ld(1'b1, LD_SETUP2, 32'hFFFF_000F);
    ahb(1'b1, ADDR_WIN2_BASE, 32'hFFFF_FFFF);
    rd_chk(ADDR_WIN2_BASE, 32'hFFFF_0008);
    ahb(1'b1, ADDR_WIN2_BASE, 32'h4000_0000);
    ld(1'b1, LD_XLAT2, 32'h7777_0000);
    dec(32'h4000_ABCD, 1'b0, 1'b1, 32'h7777_ABCD);
    ahb(1'b1, ADDR_SETUP2, 32'h7FFF_0008);
    rd_chk(ADDR_WIN2_BASE, RST_WORD);
    dec(32'h4000_ABCD, 1'b0, 1'b0, 32'h0);
    rd_chk(32'h0000_0200, RST_WORD);
    $display("test window two done");
    conclude();
  end
endmodule : dwb_bars_bench
